// ===== verilog/sfcr_pkg.sv
// sfcr_pkg: opcodes, field limits, timing figures and shared types of the serial flash command/read path
// assumes: single 10 MHz system clock; the serial link is sampled, never used as a clock
package sfcr_pkg;

  // system clock and link rates
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  localparam int unsigned READ_MAX_HZ = 25_000_000;
  localparam int unsigned FAST_READ_MAX_HZ = 50_000_000;
  localparam int unsigned SYNC_STAGES = 2;

  // framing
  localparam int unsigned BITS_PER_CYCLE = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [1:0] WORD_LAST_BYTE = 2'h1;

  // array geometry: 4 Mbit = 512 KByte
  localparam int unsigned ARRAY_ADDR_W = 19;
  localparam logic [ARRAY_ADDR_W-1:0] SECTOR_MASK = 19'h7f000;
  localparam logic [ARRAY_ADDR_W-1:0] BLK32_MASK = 19'h78000;
  localparam logic [ARRAY_ADDR_W-1:0] BLK64_MASK = 19'h70000;
  localparam logic [ARRAY_ADDR_W-1:0] WORD_MASK = 19'h7fffe;

  // opcodes
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST_READ = 8'h0b;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OPC_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OPC_BLK64_ERASE = 8'hd8;
  localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OPC_BYTE_PROG = 8'h02;
  localparam logic [7:0] OPC_WORD_PROG = 8'had;
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;
  localparam logic [7:0] OPC_READ_ID_A = 8'h90;
  localparam logic [7:0] OPC_READ_ID_B = 8'hab;
  localparam logic [7:0] OPC_BUSY_EN = 8'h70;
  localparam logic [7:0] OPC_BUSY_DIS = 8'h80;

  // values shown on the serial output
  localparam logic [7:0] UNDERRUN_BYTE = 8'hff;
  localparam logic SO_IDLE_LEVEL = 1'b1;

  typedef enum logic [2:0] {
    SFCR_OP_SECTOR_ERASE,
    SFCR_OP_BLK32_ERASE,
    SFCR_OP_BLK64_ERASE,
    SFCR_OP_CHIP_ERASE,
    SFCR_OP_BYTE_PROGRAM,
    SFCR_OP_WORD_PROGRAM
  } sfcr_op_e;

  typedef struct packed {
    sfcr_op_e kind;
    logic with_addr;
    logic [ARRAY_ADDR_W-1:0] addr;
    logic [7:0] data0;
    logic [7:0] data1;
  } sfcr_op_s;

  typedef struct packed {
    logic valid;
    logic [ARRAY_ADDR_W-1:0] addr;
  } sfcr_mem_req_s;

endpackage : sfcr_pkg

// ===== verilog/sfcr_pair_buffer.sv
// sfcr_pair_buffer: small flop FIFO with valid/ready on both sides and a synchronous flush
// assumes: one clock; in_ready_o is registered so the source sees it without a combinational path
`timescale 1ns/1ns
module sfcr_pair_buffer #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic flush_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic ready_q;
  logic push;
  logic pop;

  assign push = in_valid_i & ready_q;
  assign pop = out_valid_o & out_ready_i;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign in_ready_o = ready_q;

  always_comb begin
    cnt_d = cnt_q;
    if (flush_i) begin
      cnt_d = '0;
    end else if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != FULL);
    end
  end

  // pointers wrap at DEPTH, so non-power-of-two depths stay legal
  always_ff @(posedge clk_i) begin
    if (reset_i || flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + PW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push && !flush_i) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

endmodule : sfcr_pair_buffer

// ===== verilog/sfcr_cmd_read_path.sv
// sfcr_cmd_read_path: serial flash opcode decoder, read data path and write-command hand-off
// assumes: chip select, serial clock and serial input come from another domain and are
// oversampled by clk_i; the serial clock must be well below clk_i/4; the array answers
// read requests through the buffered response port within a few cycles
//
// How it works
// - every opcode, address, dummy and data cycle is exactly eight serial clocks
// - opcode 03 reads the array after three address bytes, no dummy byte
// - opcode 0B reads after three address bytes plus one dummy byte
// - read output starts at the given address and increments per byte until deselect
// - after the top array address the read pointer wraps to zero
// - opcode 20 with address erases a 4 KByte sector, address bits 12 upward
// - opcode 52 with address erases a 32 KByte block from upper bits
// - opcode D8 with address erases a 64 KByte block from bit 16 upward
// - opcodes 60 and C7 alone request a full array erase
// - opcode 02 with address and one data byte programs one byte
// - opcode AD: address then word; later words omit address; first byte even
// - opcode 05 streams the status byte repeatedly until deselect
// - opcodes 90/AB give maker code on even address, device code on odd, alternating
// - opcode 70 lets the serial output show ready/busy during word programming
// - opcode 80 stops the ready/busy indication on the serial output
// - address bits above the array size are ignored
// - input sampled on rising serial clock, msb first, framing restarts on select
// - deselect before an instruction completes abandons it silently
// - write commands launch on deselect after the last bit; reads just stop
`timescale 1ns/1ns
module sfcr_cmd_read_path import sfcr_pkg::*; #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h3c, // arbitrary value
  parameter int unsigned BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial link pins
  input wire logic spi_cs_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_si_i,
  output logic spi_so_o,
  output logic spi_so_oe_n_o,
  // device state from the program/erase engine
  input wire logic [7:0] status_i,
  input wire logic flash_busy_i,
  input wire logic auto_increment_program_i,
  // array read request
  output sfcr_mem_req_s mem_req_o,
  input wire logic mem_req_ready_i,
  // array read response
  input wire logic mem_rsp_valid_i,
  output logic mem_rsp_ready_o,
  input wire logic [7:0] mem_rsp_data_i,
  // write-type command hand-off
  output logic op_valid_o,
  output sfcr_op_s op_o,
  output logic busy_out_en_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA_IN, ST_DATA_OUT, ST_IGNORE
  } sfcr_state_e;

  // pin synchronisers, bit order {cs_n, sck, si}
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;

  sfcr_state_e state_q;
  sfcr_state_e state_d;
  logic [1:0] byte_cnt_q;
  logic [1:0] byte_cnt_d;
  logic done_q;
  logic done_d;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] in_byte;
  logic byte_done;
  logic [7:0] cmd_q;
  logic [23:0] addr_q;
  logic [23:0] addr_full;
  logic with_addr_q;
  logic [7:0] data0_q;
  logic [7:0] data1_q;
  logic is_read;
  logic is_id;

  // output path
  logic [2:0] out_cnt_q;
  logic [6:0] out_sr_q;
  logic [7:0] next_byte;
  logic id_sel_q;
  logic load_byte;
  logic busy_show;
  logic so_q;
  logic so_oe_n_q;
  logic busy_en_q;

  // read prefetch
  logic rd_phase;
  logic [ARRAY_ADDR_W-1:0] ptr_q;
  logic req_valid_q;
  logic wait_rsp_q;
  logic buf_valid;
  logic buf_pop;
  logic [7:0] buf_data;
  sfcr_op_s op_q;
  logic op_valid_q;

  // reset to the idle pin levels (select high, clock low) so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1_q <= 3'h4;
      s2_q <= 3'h4;
      s3_q <= 3'h4;
    end else begin
      s1_q <= {spi_cs_n_i, spi_sck_i, spi_si_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign cs_low = ~s2_q[2];
  assign cs_fall = s3_q[2] & ~s2_q[2];
  assign cs_rise = ~s3_q[2] & s2_q[2];
  assign sck_rise = cs_low & s2_q[1] & ~s3_q[1];
  assign sck_fall = cs_low & ~s2_q[1] & s3_q[1];
  assign byte_done = sck_rise && (bit_cnt_q == LAST_BIT);
  assign in_byte = {shift_q, s2_q[0]};
  assign addr_full = {addr_q[15:0], in_byte};
  assign is_read = (cmd_q == OPC_READ) || (cmd_q == OPC_FAST_READ);
  assign is_id = (cmd_q == OPC_READ_ID_A) || (cmd_q == OPC_READ_ID_B);

  // bit framing restarts on every select
  always_ff @(posedge clk_i) begin
    if (reset_i || cs_fall) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= in_byte[6:0];
    end
  end

  always_comb begin
    state_d = state_q;
    byte_cnt_d = byte_cnt_q;
    done_d = done_q;
    if (!cs_low) begin
      state_d = ST_IDLE;
      done_d = 1'b0;
    end else if (cs_fall) begin
      state_d = ST_OPCODE;
      byte_cnt_d = '0;
      done_d = 1'b0;
    end else if (byte_done) begin
      byte_cnt_d = byte_cnt_q + 2'h1;
      unique case (state_q)
        ST_OPCODE: begin
          byte_cnt_d = '0;
          case (in_byte)
            OPC_READ, OPC_FAST_READ, OPC_SECTOR_ERASE, OPC_BLK32_ERASE, OPC_BLK64_ERASE,
            OPC_BYTE_PROG, OPC_READ_ID_A, OPC_READ_ID_B: state_d = ST_ADDR;
            OPC_WORD_PROG: state_d = auto_increment_program_i ? ST_DATA_IN : ST_ADDR;
            OPC_READ_STATUS: state_d = ST_DATA_OUT;
            OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B, OPC_BUSY_EN, OPC_BUSY_DIS: begin
              state_d = ST_IGNORE;
              done_d = 1'b1;
            end
            default: state_d = ST_IGNORE;
          endcase
        end
        ST_ADDR: begin
          if (byte_cnt_q == ADDR_LAST_BYTE) begin
            byte_cnt_d = '0;
            if (cmd_q == OPC_FAST_READ) begin
              state_d = ST_DUMMY;
            end else if (is_read || is_id) begin
              state_d = ST_DATA_OUT;
            end else if (cmd_q == OPC_BYTE_PROG || cmd_q == OPC_WORD_PROG) begin
              state_d = ST_DATA_IN;
            end else begin
              state_d = ST_IGNORE;
              done_d = 1'b1;
            end
          end
        end
        ST_DUMMY: state_d = ST_DATA_OUT;
        ST_DATA_IN: begin
          if (cmd_q == OPC_BYTE_PROG || byte_cnt_q == WORD_LAST_BYTE) begin
            state_d = ST_IGNORE;
            done_d = 1'b1;
          end
        end
        ST_IDLE, ST_DATA_OUT, ST_IGNORE: state_d = state_q;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      byte_cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      byte_cnt_q <= byte_cnt_d;
      done_q <= done_d;
    end
  end

  // command, address and data capture
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_q <= '0;
      addr_q <= '0;
      with_addr_q <= 1'b0;
      data0_q <= '0;
      data1_q <= '0;
    end else if (cs_fall) begin
      with_addr_q <= 1'b0;
    end else if (byte_done) begin
      unique case (state_q)
        ST_OPCODE: cmd_q <= in_byte;
        ST_ADDR: begin
          addr_q <= addr_full;
          with_addr_q <= 1'b1;
        end
        ST_DATA_IN: begin
          if (byte_cnt_q == '0) begin
            data0_q <= in_byte;
          end else begin
            data1_q <= in_byte;
          end
        end
        ST_IDLE, ST_DUMMY, ST_DATA_OUT, ST_IGNORE: cmd_q <= cmd_q;
      endcase
    end
  end

  // write commands only launch when select rises after a complete instruction
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      op_valid_q <= 1'b0;
      op_q <= '0;
      busy_en_q <= 1'b0;
    end else begin
      op_valid_q <= 1'b0;
      if (cs_rise && done_q) begin
        op_q.with_addr <= with_addr_q;
        op_q.data0 <= data0_q;
        op_q.data1 <= data1_q;
        op_q.addr <= addr_q[ARRAY_ADDR_W-1:0];
        op_valid_q <= 1'b1;
        case (cmd_q)
          OPC_SECTOR_ERASE: begin
            op_q.kind <= SFCR_OP_SECTOR_ERASE;
            op_q.addr <= addr_q[ARRAY_ADDR_W-1:0] & SECTOR_MASK;
          end
          OPC_BLK32_ERASE: begin
            op_q.kind <= SFCR_OP_BLK32_ERASE;
            op_q.addr <= addr_q[ARRAY_ADDR_W-1:0] & BLK32_MASK;
          end
          OPC_BLK64_ERASE: begin
            op_q.kind <= SFCR_OP_BLK64_ERASE;
            op_q.addr <= addr_q[ARRAY_ADDR_W-1:0] & BLK64_MASK;
          end
          OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B: op_q.kind <= SFCR_OP_CHIP_ERASE;
          OPC_BYTE_PROG: op_q.kind <= SFCR_OP_BYTE_PROGRAM;
          OPC_WORD_PROG: begin
            op_q.kind <= SFCR_OP_WORD_PROGRAM;
            op_q.addr <= with_addr_q ? (addr_q[ARRAY_ADDR_W-1:0] & WORD_MASK) : '0;
          end
          OPC_BUSY_EN: begin
            busy_en_q <= 1'b1;
            op_valid_q <= 1'b0;
          end
          default: begin
            busy_en_q <= 1'b0;
            op_valid_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // prefetch starts during the dummy byte so the first bit is ready at the next falling edge
  assign rd_phase = cs_low && is_read && (state_q == ST_DATA_OUT || state_q == ST_DUMMY);
  assign load_byte = sck_fall && (state_q == ST_DATA_OUT) && (out_cnt_q == '0);
  assign buf_pop = load_byte && is_read;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ptr_q <= '0;
      req_valid_q <= 1'b0;
      wait_rsp_q <= 1'b0;
    end else begin
      if (byte_done && state_q == ST_ADDR && byte_cnt_q == ADDR_LAST_BYTE) begin
        ptr_q <= addr_full[ARRAY_ADDR_W-1:0];
      end else if (req_valid_q && mem_req_ready_i) begin
        ptr_q <= ptr_q + 19'h1;
      end
      if (req_valid_q && mem_req_ready_i) begin
        req_valid_q <= 1'b0;
        wait_rsp_q <= 1'b1;
      end else if (rd_phase && !req_valid_q && !wait_rsp_q && mem_rsp_ready_o) begin
        req_valid_q <= 1'b1;
      end
      if (mem_rsp_valid_i && mem_rsp_ready_o) begin
        wait_rsp_q <= 1'b0;
      end
    end
  end

  // responses arriving outside a read phase are accepted and dropped
  sfcr_pair_buffer #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH)
  ) u_rd_buf (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .flush_i(!cs_low),
    .in_valid_i(mem_rsp_valid_i && rd_phase),
    .in_ready_o(mem_rsp_ready_o),
    .in_data_i(mem_rsp_data_i),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_data)
  );

  always_comb begin
    if (cmd_q == OPC_READ_STATUS) begin
      next_byte = status_i;
    end else if (is_id) begin
      next_byte = id_sel_q ? DEVICE_CODE : MAKER_CODE;
    end else begin
      next_byte = buf_valid ? buf_data : UNDERRUN_BYTE;
    end
  end

  assign busy_show = busy_en_q && auto_increment_program_i && (state_q != ST_DATA_OUT);

  always_ff @(posedge clk_i) begin
    if (reset_i || !cs_low) begin
      out_cnt_q <= '0;
      out_sr_q <= '0;
      so_q <= SO_IDLE_LEVEL;
      so_oe_n_q <= 1'b1;
    end else if (sck_fall && state_q == ST_DATA_OUT) begin
      out_cnt_q <= out_cnt_q + 3'h1;
      so_oe_n_q <= 1'b0;
      if (load_byte) begin
        so_q <= next_byte[7];
        out_sr_q <= next_byte[6:0];
      end else begin
        so_q <= out_sr_q[6];
        out_sr_q <= {out_sr_q[5:0], 1'b0};
      end
    end else if (busy_show) begin
      so_q <= ~flash_busy_i;
      so_oe_n_q <= 1'b0;
    end else if (state_q != ST_DATA_OUT) begin
      so_oe_n_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      id_sel_q <= 1'b0;
    end else if (byte_done && state_q == ST_ADDR) begin
      id_sel_q <= in_byte[0];
    end else if (load_byte && is_id) begin
      id_sel_q <= ~id_sel_q;
    end
  end

  assign spi_so_o = so_q;
  assign spi_so_oe_n_o = so_oe_n_q;
  assign mem_req_o = {req_valid_q, ptr_q};
  assign op_valid_o = op_valid_q;
  assign op_o = op_q;
  assign busy_out_en_o = busy_en_q;

endmodule : sfcr_cmd_read_path

// ===== test/sfcr_cmd_read_path_asserts.sv
// sfcr_cmd_read_path_asserts: port checks of the command/read path
// assumes: bound to sfcr_cmd_read_path; one clk_i domain, reset_i synchronous
`timescale 1ns/1ns
module sfcr_cmd_read_path_asserts import sfcr_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial link
  input wire logic spi_cs_n_i,
  input wire logic spi_so_o,
  input wire logic spi_so_oe_n_o,
  // array read request
  input wire sfcr_mem_req_s mem_req_o,
  input wire logic mem_req_ready_i,
  // write-type hand-off
  input wire logic op_valid_o,
  input wire sfcr_op_s op_o,
  input wire logic busy_out_en_o
);
  logic have_q;
  logic [18:0] last_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // last accepted read address, forgotten while deselected so frames never chain
  always_ff @(posedge clk_i) begin
    if (reset_i || spi_cs_n_i) begin
      have_q <= 1'b0;
    end else if (mem_req_o.valid && mem_req_ready_i) begin
      have_q <= 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (mem_req_o.valid && mem_req_ready_i) begin
      last_q <= mem_req_o.addr;
    end
  end
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    reset_i |=> spi_so_oe_n_o && spi_so_o && !op_valid_o && !mem_req_o.valid && !busy_out_en_o)
    else $error("outputs not quiet after reset");
  AST_DESEL_RELEASE: assert property (spi_cs_n_i [*8] |-> spi_so_oe_n_o)
    else $error("output driven while deselected");
  AST_OP_ONE_CYCLE: assert property (op_valid_o |=> !op_valid_o)
    else $error("command pulse longer than one cycle");
  AST_OP_DESELECTED: assert property (op_valid_o |-> spi_cs_n_i && $past(spi_cs_n_i, 2))
    else $error("command launched while selected");
  AST_SECTOR_MASK: assert property (op_valid_o && op_o.kind == SFCR_OP_SECTOR_ERASE
    |-> (op_o.addr & ~SECTOR_MASK) == 19'h0) else $error("sector address not aligned");
  AST_BLK32_MASK: assert property (op_valid_o && op_o.kind == SFCR_OP_BLK32_ERASE
    |-> (op_o.addr & ~BLK32_MASK) == 19'h0) else $error("32k block address not aligned");
  AST_BLK64_MASK: assert property (op_valid_o && op_o.kind == SFCR_OP_BLK64_ERASE
    |-> (op_o.addr & ~BLK64_MASK) == 19'h0) else $error("64k block address not aligned");
  AST_REQ_HOLD: assert property (mem_req_o.valid && !mem_req_ready_i
    |=> mem_req_o.valid && $stable(mem_req_o.addr)) else $error("read request dropped");
  AST_READ_STEP: assert property (mem_req_o.valid && mem_req_ready_i && have_q && !spi_cs_n_i
    |-> mem_req_o.addr == last_q + 19'h1) else $error("read address not next");
  AST_BUSY_EN_AT_DESEL: assert property ($changed(busy_out_en_o) |-> spi_cs_n_i)
    else $error("busy output mode changed while selected");
  COV_OP: cover property (op_valid_o);
  COV_READ: cover property (mem_req_o.valid && mem_req_ready_i);
  COV_DRIVE: cover property (!spi_so_oe_n_o);
endmodule : sfcr_cmd_read_path_asserts

bind sfcr_cmd_read_path sfcr_cmd_read_path_asserts sfcr_cmd_read_path_asserts_i (.clk_i(clk_i),
  .reset_i(reset_i), .spi_cs_n_i(spi_cs_n_i), .spi_so_o(spi_so_o), .spi_so_oe_n_o(spi_so_oe_n_o),
  .mem_req_o(mem_req_o), .mem_req_ready_i(mem_req_ready_i), .op_valid_o(op_valid_o), .op_o(op_o),
  .busy_out_en_o(busy_out_en_o));

// ===== test/sfcr_spi_host.sv
// sfcr_spi_host: behavioural mode-0 serial host, 800 ns per serial clock
// assumes: the bench calls its tasks; so_i is the resolved output wire
`timescale 1ns/1ns
module sfcr_spi_host (
  // clock
  input wire logic clk_i,
  // serial link
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // nb bits msb first; reply taken late in the high phase, well after the device's fall
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      @(negedge clk_i);
      sck_o = 1'b0;
      si_o = tx[i];
      repeat (4) @(negedge clk_i);
      sck_o = 1'b1;
      repeat (3) @(negedge clk_i);
      rx[i] = so_i;
    end
  endtask : xfer
  task automatic sel();
    @(negedge clk_i);
    cs_n_o = 1'b0;
  endtask : sel
  // clock parked low before deselect; data line not left at its last value
  task automatic desel();
    @(negedge clk_i);
    sck_o = 1'b0;
    si_o = ~si_o;
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    repeat (16) @(negedge clk_i);
  endtask : desel
endmodule : sfcr_spi_host

// ===== test/sfcr_cmd_read_path_tb_top.sv
// sfcr_cmd_read_path_tb_top: self-checking bench of the command/read path
// assumes: host model on the link; the array is modelled here
`timescale 1ns/1ns
module sfcr_cmd_read_path_tb_top import sfcr_pkg::*; ();
  localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
  localparam logic [7:0] DEV = 8'h3c; // arbitrary value
  localparam logic [23:0] WADDR = 24'he2b457;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cs_n, sck, si, so_w;
  logic tgl = 1'b0;
  logic [7:0] status_i = 8'h00;
  logic flash_busy_i = 1'b0;
  logic auto_increment_program_i = 1'b0;
  logic mem_req_ready_i = 1'b1;
  logic mem_rsp_valid_i = 1'b0;
  logic [7:0] mem_rsp_data_i = 8'h00;
  logic spi_so_o, spi_so_oe_n_o, mem_rsp_ready_o, op_valid_o, busy_out_en_o;
  logic req_took, rsp_took;
  logic [18:0] req_addr;
  logic [7:0] rx;
  sfcr_mem_req_s mem_req_o;
  sfcr_op_s op_o, op_seen;
  int mismatches = 0;
  int cmp_count = 0;
  int op_cnt = 0;

  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) tgl <= ~tgl;
  // a released output shows a changing pattern, so a stale bit cannot pass
  assign so_w = spi_so_oe_n_o ? tgl : spi_so_o;

  sfcr_cmd_read_path #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEV)) sfcr_cmd_read_path_i (.clk_i(clk_i),
    .reset_i(reset_i), .spi_cs_n_i(cs_n), .spi_sck_i(sck), .spi_si_i(si), .spi_so_o(spi_so_o),
    .spi_so_oe_n_o(spi_so_oe_n_o), .status_i(status_i), .flash_busy_i(flash_busy_i),
    .auto_increment_program_i(auto_increment_program_i), .mem_req_o(mem_req_o), .mem_req_ready_i(mem_req_ready_i),
    .mem_rsp_valid_i(mem_rsp_valid_i), .mem_rsp_ready_o(mem_rsp_ready_o),
    .mem_rsp_data_i(mem_rsp_data_i), .op_valid_o(op_valid_o), .op_o(op_o), .busy_out_en_o(busy_out_en_o));
  sfcr_spi_host sfcr_spi_host_i (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so_w));

  function automatic logic [7:0] mdat(input logic [18:0] a);
    return a[7:0] + {5'h00, a[18:16]};
  endfunction : mdat
  always @(posedge clk_i) begin
    req_took <= mem_req_o.valid && mem_req_ready_i;
    rsp_took <= mem_rsp_valid_i && mem_rsp_ready_o;
    req_addr <= mem_req_o.addr;
    if (op_valid_o) begin
      op_cnt <= op_cnt + 1;
      op_seen <= op_o;
    end
  end
  // array answers half a cycle after accepting and holds the byte until taken
  always @(negedge clk_i) begin
    if (req_took) begin
      mem_rsp_valid_i = 1'b1;
      mem_rsp_data_i = mdat(req_addr);
    end else if (rsp_took) begin
      mem_rsp_valid_i = 1'b0;
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic hdr(input logic [7:0] opc, input int na, input logic [23:0] a);
    sfcr_spi_host_i.sel();
    sfcr_spi_host_i.xfer(opc, 8, rx);
    for (int i = na - 1; i >= 0; i--) sfcr_spi_host_i.xfer(a[8*i +: 8], 8, rx);
  endtask : hdr
  // stall keeps the array silent, so every byte is the fill value
  task automatic t_read(input logic [7:0] opc, input logic [23:0] a, input logic stall);
    logic [18:0] p;
    p = a[18:0];
    mem_req_ready_i = !stall;
    hdr(opc, 3, a);
    if (opc == OPC_FAST_READ) sfcr_spi_host_i.xfer(8'h00, 8, rx);
    for (int i = 0; i < 3; i++) begin
      sfcr_spi_host_i.xfer(8'h00, 8, rx);
      check(rx, stall ? UNDERRUN_BYTE : mdat(p));
      p = p + 19'h1;
    end
    sfcr_spi_host_i.desel();
    mem_req_ready_i = 1'b1;
  endtask : t_read
  task automatic t_status();
    status_i = 8'ha5;
    hdr(OPC_READ_STATUS, 0, 24'h0);
    sfcr_spi_host_i.xfer(8'h00, 8, rx);
    check(rx, 8'ha5);
    status_i = 8'h3c;
    sfcr_spi_host_i.xfer(8'h00, 8, rx);
    check(rx, 8'h3c);
    sfcr_spi_host_i.desel();
    check(spi_so_oe_n_o, 1'b1);
  endtask : t_status
  task automatic t_id(input logic [7:0] opc, input logic [23:0] a);
    hdr(opc, 3, a);
    for (int i = 0; i < 3; i++) begin
      sfcr_spi_host_i.xfer(8'h00, 8, rx);
      check(rx, (a[0] ^ i[0]) ? DEV : MAKER);
    end
    sfcr_spi_host_i.desel();
  endtask : t_id
  // each write frame follows a write enable, an opcode this block ignores
  task automatic t_write(input logic [7:0] opc, input int na, input int nd, input logic [2:0] kind,
                         input logic [18:0] ea);
    int c;
    c = op_cnt;
    hdr(8'h06, 0, WADDR);
    sfcr_spi_host_i.desel();
    check(op_cnt, c);
    hdr(opc, na, WADDR);
    for (int i = 0; i < nd; i++) sfcr_spi_host_i.xfer(8'hc1 + i[7:0], 8, rx);
    sfcr_spi_host_i.desel();
    check(op_cnt, c + 1);
    check(op_seen.kind, kind);
    check(op_seen.with_addr, na != 0);
    if (kind != 3'h3) check(op_seen.addr, ea);
    if (nd > 0) check(op_seen.data0, 8'hc1);
    if (nd > 1) check(op_seen.data1, 8'hc2);
  endtask : t_write
  task automatic t_abort();
    int c;
    c = op_cnt;
    hdr(OPC_BYTE_PROG, 3, WADDR);
    sfcr_spi_host_i.xfer(8'h55, 4, rx);
    sfcr_spi_host_i.desel();
    check(op_cnt, c);
  endtask : t_abort
  task automatic t_busy();
    hdr(OPC_BUSY_EN, 0, WADDR);
    sfcr_spi_host_i.desel();
    check(busy_out_en_o, 1'b1);
    auto_increment_program_i = 1'b1;
    flash_busy_i = 1'b1;
    sfcr_spi_host_i.sel();
    repeat (8) @(negedge clk_i);
    check({spi_so_oe_n_o, so_w}, 2'b00);
    flash_busy_i = 1'b0;
    repeat (8) @(negedge clk_i);
    check({spi_so_oe_n_o, so_w}, 2'b01);
    sfcr_spi_host_i.desel();
    hdr(OPC_BUSY_DIS, 0, WADDR);
    sfcr_spi_host_i.desel();
    check(busy_out_en_o, 1'b0);
    sfcr_spi_host_i.sel();
    repeat (8) @(negedge clk_i);
    check(spi_so_oe_n_o, 1'b1);
    sfcr_spi_host_i.desel();
    auto_increment_program_i = 1'b0;
  endtask : t_busy

  initial begin
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    check({spi_so_oe_n_o, op_valid_o}, 2'b10);
    t_read(OPC_READ, 24'hf7fffe, 1'b0);
    t_read(OPC_FAST_READ, 24'h000010, 1'b0);
    t_read(OPC_READ, 24'h000100, 1'b1);
    t_status();
    t_id(OPC_READ_ID_A, 24'h000000);
    t_id(OPC_READ_ID_B, 24'h000001);
    t_write(OPC_SECTOR_ERASE, 3, 0, SFCR_OP_SECTOR_ERASE, 19'h2b000);
    t_write(OPC_BLK32_ERASE, 3, 0, SFCR_OP_BLK32_ERASE, 19'h28000);
    t_write(OPC_BLK64_ERASE, 3, 0, SFCR_OP_BLK64_ERASE, 19'h20000);
    t_write(OPC_CHIP_ERASE_A, 0, 0, SFCR_OP_CHIP_ERASE, 19'h0);
    t_write(OPC_CHIP_ERASE_B, 0, 0, SFCR_OP_CHIP_ERASE, 19'h0);
    t_write(OPC_BYTE_PROG, 3, 1, SFCR_OP_BYTE_PROGRAM, 19'h2b457);
    t_write(OPC_WORD_PROG, 3, 2, SFCR_OP_WORD_PROGRAM, 19'h2b456);
    auto_increment_program_i = 1'b1;
    t_write(OPC_WORD_PROG, 0, 2, SFCR_OP_WORD_PROGRAM, 19'h0);
    auto_increment_program_i = 1'b0;
    t_abort();
    t_busy();
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    mismatches++;
    end_sim();
  end
endmodule : sfcr_cmd_read_path_tb_top
